// file: ptu_pkg.sv
// package: constants and types of the trace event unit
`default_nettype none
package ptu_pkg;
   // register byte offsets on the bus
   localparam logic [3:0] REG_TC   = 4'h0;
   localparam logic [3:0] REG_PC   = 4'h4;
   localparam logic [3:0] REG_STAT = 4'h8;
   // trace control word mode bit positions
   localparam int TC_INST = 1;
   localparam int TC_BRN  = 2;
   localparam int TC_CAL  = 3;
   localparam int TC_RET  = 4;
   localparam int TC_PRE  = 5;
   localparam int TC_SUP  = 6;
   localparam int TC_MRK  = 7;
   // breakpoint event flags: bits 8..15 and 24..27
   localparam logic [31:0] TC_RSVD_MASK = 32'hF0FF_0001;
   localparam logic [31:0] TC_EVT_MASK  = 32'h0F00_FF00;
   localparam logic [31:0] TC_RESET     = 32'h0000_0000;
   localparam int GLOBAL_TRACE_ENABLE_BIT   = 0;
   localparam int ST_PEND_BIT = 0;
   localparam int ST_PRE_BIT  = 1;
   localparam int ST_HDL_BIT  = 2;
   localparam int BP_N        = 12;
   // return type field codes
   localparam logic [2:0] RET_LOCAL = 3'h0;
   localparam logic [2:0] RET_FAULT = 3'h1;
   localparam logic [1:0] RET_SYS   = 2'h1;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ    = 2'h3;

   typedef enum logic [1:0] {
      ST_RUN     = 2'b01,
      ST_HANDLER = 2'b10
   } ptu_state_e;

   // one retired (or about to retire) instruction from the core
   typedef struct packed {
      logic       valid;
      logic       is_branch;
      logic       taken;
      logic       is_bal;
      logic       is_call;
      logic       is_sys_call;
      logic       sys_to_super;
      logic       fault_call;
      logic       int_call;
      logic       is_ret;
      logic [2:0] ret_type;
      logic       super_mode;
      logic       preret_flag;
      logic       is_mark;
      logic       is_fmark;
   } ptu_retire_s;

   // kind of a raised trace fault
   typedef struct packed {
      logic inst;
      logic brn;
      logic cal;
      logic ret;
      logic pre;
      logic sup;
      logic mrk;
      logic bpt;
   } ptu_kind_s;

   typedef struct packed {
      ptu_state_e     st;
      logic [31:0]    tc;
      logic           te;
      logic           te_saved;
      logic           pend;
      ptu_kind_s      pend_kind;
      logic           preret_pend;
      logic           init_done;
      logic           fault;
      ptu_kind_s      kind;
      logic           set_pfp;
      logic           pfp_new;
      logic           wr_pend;
      logic [3:0]     wr_off;
      logic [31:0]    rdata;
   } ptu_q_s;
endpackage : ptu_pkg
`default_nettype wire

// file: ptu_trace_event_unit.sv
// trace event detection and trace fault generation with bus registers
// Operation
// (RL1) trace enable gates all mode faults
// (RL2) event raises fault and handler call
// (RL3) init loads control word, software updates
// (RL4) enable by software, calls apply immediately
// (RL5) breakpoint flags set in handler, cleared
// (RL6) reserved control bits stay zero
// (RL7) coincident event first, trace pending
// (RL8) single step faults every instruction
// (RL9) branch trace on taken branches only
// (RL10) call trace, never interrupt calls
// (RL11) implicit fault call also call traced
// (RL12) call trace fault sets prereturn flag
// (RL13) return trace on explicit returns
// (RL14) fault return traced, interrupt never
// (RL15) prereturn faults before exit instruction
// (RL16) prereturn waits behind other trace
// (RL17) modes enabled independently
// (RL18) twelve breakpoint match events
// (RL19) mark instructions create events
// (RL20) supervisor trace on kernel boundaries
// (RL21) mark by mode, forced mark always
// (RL22) mode and flag bits avoid reserved
//
// Our own choices: the address map and the AHB-Lite interface to the registers.
`default_nettype none
module ptu_trace_event_unit
   import ptu_pkg::*;
(
   input  wire logic              hclk,
   input  wire logic              hresetn,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic                   hresp,
   output logic [31:0]            hrdata,
   input  wire logic [31:0]       init_tc,
   input  wire ptu_retire_s       rt,
   input  wire logic [BP_N-1:0]   bp_match,
   input  wire logic              te_upd,
   input  wire logic              te_upd_val,
   input  wire logic              other_event,
   input  wire logic              other_ret,
   input  wire logic              handler_ret,
   output logic                   trace_fault,
   output ptu_kind_s              trace_kind,
   output logic                   set_preret,
   output logic                   preret_new_frame,
   output logic                   trace_pending
);
   ptu_q_s q;
   ptu_q_s next_q;

   logic        te_eff;
   logic        ev_inst;
   logic        ev_brn;
   logic        ev_cal;
   logic        ev_ret;
   logic        ev_pre;
   logic        ev_sup;
   logic        ev_mrk;
   logic        ev_bpt;
   logic        ev_other;
   logic        addr_ok;
   logic [31:0] bp_flags;

   // call and return update the enable at once
   assign te_eff = te_upd ? te_upd_val : q.te;  // see (RL4)

   // each mode is tested on its own bit
   assign ev_inst = rt.valid && q.tc[TC_INST];  // see (RL8) (RL17)
   assign ev_brn = rt.valid && q.tc[TC_BRN]
                   && rt.is_branch && rt.taken
                   && !rt.is_bal && !rt.is_call
                   && !rt.is_ret;  // see (RL9)
   // interrupt calls are excluded outright
   assign ev_cal = rt.valid && q.tc[TC_CAL]
                   && (rt.is_call || rt.is_sys_call || rt.is_bal
                       || rt.fault_call)
                   && !rt.int_call;  // see (RL10) (RL11)
   assign ev_ret = rt.valid && q.tc[TC_RET] && rt.is_ret
                   && (rt.ret_type == RET_LOCAL
                       || rt.ret_type == RET_FAULT
                       || rt.ret_type[2:1] == RET_SYS);  // see (RL13) (RL14)
   assign ev_pre = rt.valid && q.tc[TC_PRE] && rt.is_ret
                   && rt.preret_flag;  // see (RL15)
   assign ev_sup = rt.valid && q.tc[TC_SUP]
                   && ((rt.is_sys_call && !rt.super_mode
                        && rt.sys_to_super)
                       || (rt.is_ret && rt.super_mode
                           && rt.ret_type[2:1] == RET_SYS));  // see (RL20)
   assign ev_mrk = rt.valid && ((q.tc[TC_MRK] && rt.is_mark)
                                || rt.is_fmark);  // see (RL19) (RL21)
   assign ev_bpt = |bp_match;  // see (RL18)
   assign ev_other = ev_inst || ev_brn || ev_cal || ev_ret
                     || ev_sup || ev_mrk || ev_bpt;

   // breakpoint matches mapped onto the event flag bits
   assign bp_flags = {4'h0, bp_match[11:8], 8'h00,
                      bp_match[7:0], 8'h00};  // see (RL22)

   assign addr_ok = hsel && hready
                    && (htrans == HTRANS_NONSEQ
                        || htrans == HTRANS_SEQ);

   // next state; one process for the whole unit
   always_comb begin
      ptu_kind_s rk;
      logic      raise;
      rk = '0;
      raise = 1'b0;
      next_q = q;
      next_q.fault = 1'b0;
      next_q.kind = '0;
      next_q.set_pfp = 1'b0;
      next_q.pfp_new = 1'b0;

      // control word comes from the control table once
      if (!q.init_done) begin
         next_q.init_done = 1'b1;
         next_q.tc = init_tc & ~TC_RSVD_MASK;  // see (RL3) (RL6)
      end

      // write data phase of an earlier address phase
      if (q.wr_pend) begin
         if (q.wr_off == REG_TC) begin
            next_q.tc = hwdata & ~TC_RSVD_MASK;  // see (RL3) (RL6)
         end
         if (q.wr_off == REG_PC) begin
            next_q.te = hwdata[GLOBAL_TRACE_ENABLE_BIT];  // see (RL4)
         end
      end
      if (te_upd) begin
         next_q.te = te_upd_val;  // see (RL4)
      end

      // address phase: latch write, register read data
      next_q.wr_pend = addr_ok && hwrite;
      next_q.wr_off = haddr[3:0];
      if (addr_ok && !hwrite) begin
         unique case (haddr[3:0])
            REG_TC:   next_q.rdata = q.tc;
            REG_PC:   next_q.rdata = {31'h0, q.te};
            REG_STAT: next_q.rdata = {29'h0,
                                      q.st == ST_HANDLER,
                                      q.preret_pend,
                                      q.pend};
            default:  next_q.rdata = 32'h0;
         endcase
      end

      unique case (q.st)
         ST_RUN: begin
            if (te_eff && (ev_other || ev_pre)) begin  // see (RL1)
               rk.inst = ev_inst;
               rk.brn = ev_brn;
               rk.cal = ev_cal;
               rk.ret = ev_ret;
               rk.sup = ev_sup;
               rk.mrk = ev_mrk;
               rk.bpt = ev_bpt;
               // prereturn only alone; else remembered
               rk.pre = ev_pre && !ev_other;  // see (RL16)
               next_q.preret_pend = ev_pre && ev_other;  // see (RL16)
               if (other_event) begin
                  // other event goes first, trace held
                  next_q.pend = 1'b1;  // see (RL7)
                  next_q.pend_kind = rk;
               end else begin
                  raise = 1'b1;
               end
            end else if (q.pend && other_ret && te_eff) begin
               rk = q.pend_kind;  // see (RL7)
               next_q.pend = 1'b0;
               raise = 1'b1;
            end
         end
         ST_HANDLER: begin
            if (handler_ret) begin
               // leaving the handler restores tracing
               next_q.te = q.te_saved;  // see (RL4)
               next_q.tc = next_q.tc & ~TC_EVT_MASK;  // see (RL5)
               next_q.st = ST_RUN;
               if (q.preret_pend && q.te_saved) begin
                  rk.pre = 1'b1;  // see (RL16)
                  next_q.preret_pend = 1'b0;
                  raise = 1'b1;
               end
            end
         end
         default: begin
            next_q.st = ST_RUN;
         end
      endcase

      // fault entry: implicit call, tracing off inside
      if (raise) begin
         next_q.fault = 1'b1;  // see (RL2)
         next_q.kind = rk;
         next_q.st = ST_HANDLER;
         next_q.te_saved = next_q.te;
         next_q.te = 1'b0;
         if (rk.bpt) begin
            next_q.tc = next_q.tc | bp_flags;  // see (RL5)
         end
         if (rk.cal) begin
            next_q.set_pfp = 1'b1;  // see (RL12)
            next_q.pfp_new = !rt.is_bal;  // see (RL12)
         end
      end
   end

   // state register; reset gives constants only
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= '{st: ST_RUN, tc: TC_RESET, default: '0};
      end else begin
         q <= next_q;
      end
   end

   // zero wait state slave, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = q.rdata;
   assign trace_fault = q.fault;
   assign trace_kind = q.kind;
   assign set_preret = q.set_pfp;
   assign preret_new_frame = q.pfp_new;
   assign trace_pending = q.pend;

   // no fault from running state without trace enable
   property p_no_te;
      @(posedge hclk) disable iff (!hresetn)
      (q.st == ST_RUN && !te_eff) |=> !q.fault;
   endproperty
   a_no_te: assert property (p_no_te)  // see (RL1)
      else $error("trace fault without trace enable");

   // single step: fault right after the instruction
   property p_step;
      @(posedge hclk) disable iff (!hresetn)
      (q.st == ST_RUN && te_eff && rt.valid
       && q.tc[TC_INST] && !other_event)
      |=> (q.fault && q.kind.inst && q.st == ST_HANDLER
           && !q.te);
   endproperty
   a_step: assert property (p_step)  // see (RL8) (RL2)
      else $error("single step fault missing");

   // untaken and linking branches never branch traced
   property p_brn;
      @(posedge hclk) disable iff (!hresetn)
      (rt.is_bal || rt.is_call || rt.is_ret || !rt.taken)
      |=> !q.kind.brn;
   endproperty
   a_brn: assert property (p_brn)  // see (RL9)
      else $error("branch trace on wrong instruction");

   // interrupt calls are not call traced
   property p_int_call;
      @(posedge hclk) disable iff (!hresetn)
      rt.int_call |=> !q.kind.cal;
   endproperty
   a_int_call: assert property (p_int_call)  // see (RL10)
      else $error("interrupt call was traced");

   // call trace fault comes with prereturn flag set
   property p_pfp;
      @(posedge hclk) disable iff (!hresetn)
      q.fault && q.kind.cal |-> q.set_pfp;
   endproperty
   a_pfp: assert property (p_pfp)  // see (RL12)
      else $error("prereturn flag not set on call trace");

   // event flags clear after handler return
   property p_flags;
      @(posedge hclk) disable iff (!hresetn)
      (q.st == ST_HANDLER && handler_ret)
      |=> (q.tc & TC_EVT_MASK) == 32'h0;
   endproperty
   a_flags: assert property (p_flags)  // see (RL5)
      else $error("event flags left set after return");

   // reserved bits of the control word never set
   property p_rsvd;
      @(posedge hclk) disable iff (!hresetn)
      (q.tc & TC_RSVD_MASK) == 32'h0;
   endproperty
   a_rsvd: assert property (p_rsvd)  // see (RL6)
      else $error("reserved control bit set");

   // coincident event: trace held pending, no fault
   property p_pend;
      @(posedge hclk) disable iff (!hresetn)
      (q.st == ST_RUN && te_eff && ev_other && other_event)
      |=> (q.pend && !q.fault);
   endproperty
   a_pend: assert property (p_pend)  // see (RL7)
      else $error("coincident trace not held pending");

   // interrupt returns never return traced
   property p_int_ret;
      @(posedge hclk) disable iff (!hresetn)
      (rt.is_ret && rt.ret_type[2:1] == 2'h3) |=> !q.kind.ret;
   endproperty
   a_int_ret: assert property (p_int_ret)  // see (RL14)
      else $error("interrupt return was traced");

   // prereturn behind another trace is held back first
   property p_pre1;
      @(posedge hclk) disable iff (!hresetn)
      (q.st == ST_RUN && te_eff && ev_pre && ev_other
       && !other_event)
      |=> (q.preret_pend && q.fault && !q.kind.pre);
   endproperty
   a_pre1: assert property (p_pre1)  // see (RL16)
      else $error("prereturn not held behind other trace");

   // held prereturn fires on return from the first handler
   property p_pre2;
      @(posedge hclk) disable iff (!hresetn)
      (q.st == ST_HANDLER && handler_ret && q.preret_pend
       && q.te_saved)
      |=> (q.fault && q.kind.pre);
   endproperty
   a_pre2: assert property (p_pre2)  // see (RL16)
      else $error("second prereturn fault missing");

   // explicit calls, system call included, are call traced
   property p_cal;
      @(posedge hclk) disable iff (!hresetn)
      (q.st == ST_RUN && te_eff && !other_event && rt.valid
       && q.tc[TC_CAL] && !rt.int_call
       && (rt.is_call || rt.is_sys_call || rt.is_bal))
      |=> (q.fault && q.kind.cal && q.set_pfp);
   endproperty
   a_cal: assert property (p_cal)  // see (RL10)
      else $error("call trace fault missing");

   // local return is return traced
   property p_ret;
      @(posedge hclk) disable iff (!hresetn)
      (q.st == ST_RUN && te_eff && !other_event && rt.valid
       && q.tc[TC_RET] && rt.is_ret && rt.ret_type == 3'h0)
      |=> (q.fault && q.kind.ret);
   endproperty
   a_ret: assert property (p_ret)  // see (RL13)
      else $error("return trace fault missing");

   // supervisor exit of a system call is supervisor traced
   property p_sup;
      @(posedge hclk) disable iff (!hresetn)
      (q.st == ST_RUN && te_eff && !other_event && rt.valid
       && q.tc[TC_SUP] && rt.is_ret && rt.super_mode
       && rt.ret_type[2:1] == 2'h1)
      |=> (q.fault && q.kind.sup);
   endproperty
   a_sup: assert property (p_sup)  // see (RL20)
      else $error("supervisor trace fault missing");

   // forced mark faults whatever the mode bits say
   property p_fmark;
      @(posedge hclk) disable iff (!hresetn)
      (q.st == ST_RUN && te_eff && !other_event && rt.valid
       && rt.is_fmark)
      |=> (q.fault && q.kind.mrk);
   endproperty
   a_fmark: assert property (p_fmark)  // see (RL21)
      else $error("forced mark fault missing");

   // inside the handler nothing faults until it returns
   property p_quiet;
      @(posedge hclk) disable iff (!hresetn)
      (q.st == ST_HANDLER && !handler_ret) |=> !q.fault;
   endproperty
   a_quiet: assert property (p_quiet)  // see (RL2)
      else $error("trace fault raised inside handler");

   // handler return restores the saved enable
   property p_te_back;
      @(posedge hclk) disable iff (!hresetn)
      (q.st == ST_HANDLER && handler_ret && !te_upd
       && !q.preret_pend && !q.wr_pend)
      |=> q.te == $past(q.te_saved);
   endproperty
   a_te_back: assert property (p_te_back)  // see (RL4)
      else $error("trace enable not restored");
endmodule : ptu_trace_event_unit
`default_nettype wire

// file: tb_processor_trace_event_unit.sv
// testbench: trace event unit driven over its bus and retire ports
`default_nettype none
module tb_processor_trace_event_unit import ptu_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   // one table row: mode word, retired instruction, matches, expected kind
   typedef struct packed {
      logic [31:0] tc;
      ptu_retire_s r;
      logic [11:0] bp;
      logic [7:0]  k;
   } ptu_tb_row_s;

   localparam logic [31:0] M_I = 32'h1 << TC_INST;
   localparam logic [31:0] M_B = 32'h1 << TC_BRN;
   localparam logic [31:0] M_C = 32'h1 << TC_CAL;
   localparam logic [31:0] M_R = 32'h1 << TC_RET;
   localparam logic [31:0] M_P = 32'h1 << TC_PRE;
   localparam logic [31:0] M_S = 32'h1 << TC_SUP;
   localparam logic [31:0] M_M = 32'h1 << TC_MRK;
   localparam ptu_retire_s R_NOP = '{valid:1'b1, default:'0};
   localparam ptu_retire_s R_BRT = '{valid:1'b1, is_branch:1'b1,
                                     taken:1'b1, default:'0};
   localparam ptu_retire_s R_BRN = '{valid:1'b1, is_branch:1'b1, default:'0};
   localparam ptu_retire_s R_BAL = '{valid:1'b1, is_bal:1'b1, default:'0};
   localparam ptu_retire_s R_CAL = '{valid:1'b1, is_call:1'b1, default:'0};
   localparam ptu_retire_s R_INT = '{valid:1'b1, int_call:1'b1, default:'0};
   localparam ptu_retire_s R_FLT = '{valid:1'b1, fault_call:1'b1,
                                     default:'0};
   localparam ptu_retire_s R_SYS = '{valid:1'b1, is_sys_call:1'b1,
                                     sys_to_super:1'b1, default:'0};
   localparam ptu_retire_s R_R0 = '{valid:1'b1, is_ret:1'b1, default:'0};
   localparam ptu_retire_s R_R2 = '{valid:1'b1, is_ret:1'b1, ret_type:3'h2,
                                    super_mode:1'b1, default:'0};
   localparam ptu_retire_s R_R2U = '{valid:1'b1, is_ret:1'b1, ret_type:3'h2,
                                     default:'0};
   localparam ptu_retire_s R_R3 = '{valid:1'b1, is_ret:1'b1, ret_type:3'h3,
                                    default:'0};
   localparam ptu_retire_s R_R7 = '{valid:1'b1, is_ret:1'b1, ret_type:3'h7,
                                    default:'0};
   localparam ptu_retire_s R_MK = '{valid:1'b1, is_mark:1'b1, default:'0};
   localparam ptu_retire_s R_FM = '{valid:1'b1, is_fmark:1'b1, default:'0};
   localparam ptu_retire_s R_PR = '{valid:1'b1, is_ret:1'b1,
                                    preret_flag:1'b1, default:'0};

   // kind bits {inst,brn,cal,ret,pre,sup,mrk,bpt}
   localparam ptu_tb_row_s ROWS [24] = '{
      '{M_I, R_BRN, 12'h000, 8'h80},
      '{M_B, R_BRT, 12'h000, 8'h40},
      '{M_B, R_BRN, 12'h000, 8'h00},
      '{M_B, R_BAL, 12'h000, 8'h00},
      '{M_B, R_CAL, 12'h000, 8'h00},
      '{M_C, R_CAL, 12'h000, 8'h20},
      '{M_C, R_BAL, 12'h000, 8'h20},
      '{M_C, R_INT, 12'h000, 8'h00},
      '{M_C, R_FLT, 12'h000, 8'h20},
      '{M_R, R_R0, 12'h000, 8'h10},
      '{M_R, R_R2U, 12'h000, 8'h10},
      '{M_R, R_R3, 12'h000, 8'h10},
      '{M_R, R_R7, 12'h000, 8'h00},
      '{M_S, R_SYS, 12'h000, 8'h04},
      '{M_S, R_R2, 12'h000, 8'h04},
      '{M_S, R_R2U, 12'h000, 8'h00},
      '{M_M, R_MK, 12'h000, 8'h02},
      '{32'h0, R_MK, 12'h000, 8'h00},
      '{32'h0, R_FM, 12'h000, 8'h02},
      '{32'h0, R_NOP, 12'h001, 8'h01},
      '{32'h0, R_NOP, 12'h800, 8'h01},
      '{M_C | M_S, R_SYS, 12'h000, 8'h24},
      '{M_P, R_PR, 12'h000, 8'h08},
      '{32'h0, R_NOP, 12'h000, 8'h00}
   };

   logic              hclk;
   logic              hresetn;
   logic              hsel;
   logic              hwrite;
   logic              hreadyout;
   logic              hresp;
   logic [1:0]        htrans;
   logic [2:0]        hsize;
   logic [31:0]       haddr;
   logic [31:0]       hwdata;
   logic [31:0]       hrdata;
   logic [31:0]       init_tc;
   logic [31:0]       rdat;
   ptu_retire_s       rt;
   logic [BP_N-1:0]   bp_match;
   logic              te_upd;
   logic              te_upd_val;
   logic              other_event;
   logic              other_ret;
   logic              handler_ret;
   logic              trace_fault;
   ptu_kind_s         trace_kind;
   logic              set_preret;
   logic              preret_new_frame;
   logic              trace_pending;
   int                failures;
   int                tests_run;

   // the single slave's ready closes the loop as the bus's ready
   ptu_trace_event_unit ptu_trace_event_unit_i (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .init_tc(init_tc), .rt(rt), .bp_match(bp_match),
      .te_upd(te_upd), .te_upd_val(te_upd_val), .other_event(other_event),
      .other_ret(other_ret), .handler_ret(handler_ret),
      .trace_fault(trace_fault), .trace_kind(trace_kind),
      .set_preret(set_preret), .preret_new_frame(preret_new_frame),
      .trace_pending(trace_pending)
   );

   // 50 MHz core clock
   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // single word transfer; waits on ready instead of assuming a latency
   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {28'h0, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rdat = hrdata;
   endtask : bus

   // one retired instruction; returns where the fault pulse has landed
   task automatic fire(input ptu_retire_s r, input logic [11:0] b);
      rt <= r;
      bp_match <= b;
      @(posedge hclk);
      rt <= '0;
      bp_match <= '0;
      te_upd <= 1'b0;
      other_event <= 1'b0;
      #1;
   endtask : fire

   task automatic hret();
      @(posedge hclk);
      handler_ret <= 1'b1;
      @(posedge hclk);
      handler_ret <= 1'b0;
      #1;
   endtask : hret

   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : conclude

   // cuts a hang short; the whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge hclk);
      failures++;
      conclude();
   end

   initial begin
      failures = 0;
      tests_run = 0;
      {hsel, hwrite, te_upd, te_upd_val, other_event} = '0;
      {other_ret, handler_ret} = '0;
      htrans = 2'h0;
      hsize = 3'h2;
      haddr = '0;
      hwdata = '0;
      rt = '0;
      bp_match = '0;
      init_tc = 32'hF0FF_00FF;
      hresetn = 1'b0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      // control word loaded at start-up with reserved bits dropped
      bus(1'b0, REG_TC, 32'h0);
      chk(rdat, 32'h0000_00FE);
      chk({31'h0, hresp}, 32'h0);
      bus(1'b1, REG_TC, 32'hF0FF_0003);
      bus(1'b0, REG_TC, 32'h0);
      chk(rdat, 32'h0000_0002);
      bus(1'b0, 4'hC, 32'h0);
      chk(rdat, 32'h0);
      bus(1'b1, REG_PC, 32'h1);
      foreach (ROWS[i]) begin
         bus(1'b1, REG_TC, ROWS[i].tc);
         fire(ROWS[i].r, ROWS[i].bp);
         chk({31'h0, trace_fault}, {31'h0, |ROWS[i].k});
         chk({24'h0, trace_kind}, {24'h0, ROWS[i].k});
         chk({31'h0, set_preret}, {31'h0, ROWS[i].k[5]});
         // a call opens a new frame, a branch-and-link keeps it
         if (ROWS[i].k[5])
            chk({31'h0, preret_new_frame},
                {31'h0, !ROWS[i].r.is_bal});
         if (|ROWS[i].k)
            hret();
      end
      // enable clear: even the forced mark stays quiet
      bus(1'b1, REG_PC, 32'h0);
      bus(1'b1, REG_TC, M_I | M_M);
      fire(R_FM, 12'h000);
      chk({31'h0, trace_fault}, 32'h0);
      // enable changed by a call counts in the very same cycle
      te_upd <= 1'b1;
      te_upd_val <= 1'b1;
      fire(R_NOP, 12'h000);
      chk({24'h0, trace_kind}, 32'h80);
      hret();
      te_upd <= 1'b1;
      te_upd_val <= 1'b0;
      fire(R_NOP, 12'h000);
      chk({31'h0, trace_fault}, 32'h0);
      // coincident non-trace event goes first, trace waits as pending
      bus(1'b1, REG_PC, 32'h1);
      other_event <= 1'b1;
      fire(R_NOP, 12'h000);
      chk({31'h0, trace_fault}, 32'h0);
      chk({31'h0, trace_pending}, 32'h1);
      @(posedge hclk);
      other_ret <= 1'b1;
      @(posedge hclk);
      other_ret <= 1'b0;
      #1;
      chk({24'h0, trace_kind}, 32'h80);
      hret();
      // prereturn behind another trace: two faults at one boundary
      bus(1'b1, REG_TC, M_I | M_P);
      fire(R_PR, 12'h000);
      chk({24'h0, trace_kind}, 32'h80);
      hret();
      chk({31'h0, trace_fault}, 32'h1);
      chk({24'h0, trace_kind}, 32'h08);
      hret();
      // breakpoint flag shows only while its handler runs
      bus(1'b1, REG_TC, M_I);
      fire(R_NOP, 12'h001);
      chk({24'h0, trace_kind}, 32'h81);
      bus(1'b0, REG_TC, 32'h0);
      chk(rdat & TC_EVT_MASK, 32'h0000_0100);
      fire(R_NOP, 12'h000);
      chk({31'h0, trace_fault}, 32'h0);
      hret();
      bus(1'b0, REG_TC, 32'h0);
      chk(rdat, M_I);
      // reset in mid-run: outputs drop, control word reloads
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      #1;
      chk(hrdata, 32'h0);
      chk({31'h0, trace_pending}, 32'h0);
      chk({31'h0, trace_fault}, 32'h0);
      @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      bus(1'b0, REG_TC, 32'h0);
      chk(rdat, init_tc & ~TC_RSVD_MASK);
      conclude();
   end
endmodule : tb_processor_trace_event_unit
`default_nettype wire
